//--- rtl/pic_event_rx.sv
// toggle receiver: synchronises a toggle and emits a one-cycle pulse
`default_nettype none
module pic_event_rx (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic tglIn,
  output logic      pulse
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
    logic pulse;
  } pic_erx_type;

  pic_erx_type cur_ff;
  pic_erx_type nxt_cur;

  // edge of the synchronised toggle becomes a pulse
  always_comb begin
    nxt_cur       = cur_ff;
    nxt_cur.meta  = tglIn;
    nxt_cur.sync  = cur_ff.meta;
    nxt_cur.last  = cur_ff.sync;
    nxt_cur.pulse = cur_ff.sync ^ cur_ff.last;
  end

  // synchronous reset to the idle toggle level
  always_ff @(posedge clk) begin
    if (rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign pulse = cur_ff.pulse;
endmodule : pic_event_rx
`default_nettype wire

//--- rtl/pic_level_sync.sv
// two flip-flop synchroniser for a single level
`default_nettype none
module pic_level_sync (
  input  wire logic clk,
  input  wire logic din,
  output logic      dout
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic meta;
    logic sync;
  } pic_lsync_type;

  pic_lsync_type cur_ff;
  pic_lsync_type nxt_cur;

  // first stage feeds only the second stage
  always_comb begin
    nxt_cur      = cur_ff;
    nxt_cur.meta = din;
    nxt_cur.sync = cur_ff.meta;
  end

  // no reset: this carries the reset itself into the link domain
  always_ff @(posedge clk) begin
    cur_ff <= nxt_cur;
  end

  assign dout = cur_ff.sync;
endmodule : pic_level_sync
`default_nettype wire

//--- rtl/pic_pkg.sv
// shared constants for the identity, compensation and regulator registers
`default_nettype none
package pic_pkg;
  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_CHIP_ID  = 8'had;
  localparam logic [7:0] CMD_CHIP_REV = 8'hae;
  localparam logic [7:0] CMD_COMP     = 8'hb1;
  localparam logic [7:0] CMD_REGV     = 8'hb5;

  // ----------------------------------------------------------------
  // block lengths in data bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] LEN_CHIP_ID  = 8'h06;
  localparam logic [7:0] LEN_CHIP_REV = 8'h02;
  localparam logic [7:0] LEN_COMP     = 8'h05;
  localparam logic [7:0] LEN_REGV     = 8'h01;
  localparam logic [7:0] LEN_NONE     = 8'h00;

  // byte index reached after count byte plus all data bytes
  localparam logic [2:0] IDX_COMP_DONE = 3'h6;
  localparam logic [2:0] IDX_REGV_DONE = 3'h2;
  localparam logic [2:0] IDX_SAT       = 3'h7;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [39:0] COMP_RESET      = 40'h0000000000;
  localparam logic [3:0]  REGV_CODE_RESET = 4'h9;
  localparam logic [3:0]  REGV_LOW_RESET  = 4'h0;

  // valid regulator codes, 3.9 v up to 5.3 v in 0.2 v steps
  localparam logic [3:0] REGV_CODE_MIN = 4'h3;
  localparam logic [3:0] REGV_CODE_MAX = 4'ha;
  localparam int         REGV_CODE_LSB = 4;

  // ----------------------------------------------------------------
  // compensation word field positions
  // ----------------------------------------------------------------
  localparam int CZI_HI_LSB  = 24;
  localparam int CZI_LO_LSB  = 38;
  localparam int CPI_LSB     = 33;
  localparam int CZI_MUL_BIT = 32;
  localparam int RVI_LSB     = 26;
  localparam int CZV_HI_LSB  = 8;
  localparam int CZV_LO_LSB  = 22;
  localparam int CPV_LSB     = 17;
  localparam int RVV_LSB     = 10;
  localparam int GMV_LSB     = 4;
  localparam int GMI_LSB     = 0;
endpackage : pic_pkg
`default_nettype wire

//--- rtl/pic_pmbus_regs.sv
// identity, revision, compensation and regulator command registers
`default_nettype none
module pic_pmbus_regs #(
  parameter logic [47:0] CHIP_ID_VALUE  = 48'h0123456789ab, // arbitrary
  parameter logic [15:0] CHIP_REV_VALUE = 16'h1000          // arbitrary
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       linkClk,
  input  wire logic       linkCmdValid,
  input  wire logic [7:0] linkCmd,
  input  wire logic       linkWrValid,
  input  wire logic [7:0] linkWrData,
  input  wire logic       linkRdReq,
  input  wire logic       linkEnd,
  output logic      [7:0] linkRdData,
  output logic            linkRdValid,
  input  wire logic       convEnable,
  input  wire logic       restoreStrobe,
  input  wire logic       statusClear,
  output logic      [3:0] currentIntegratorCapSelect,
  output logic      [4:0] currentFilterCapSelect,
  output logic            currentIntegratorMultiplier,
  output logic      [5:0] currentGainResistorSelect,
  output logic      [3:0] voltageIntegratorCapSelect,
  output logic      [4:0] voltageFilterCapSelect,
  output logic      [5:0] voltageGainResistorSelect,
  output logic      [1:0] voltageTransconductanceSelect,
  output logic      [1:0] currentTransconductanceSelect,
  output logic      [3:0] internalRegulatorCode,
  output logic            invalidCommandFlag,
  output logic            invalidDataFlag,
  output logic            cmlSummary,
  output logic            alertN
);
  // ----------------------------------------------------------------
  // state types, one per clock domain
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  cmd;
    logic [2:0]  idx;
    logic        wrote;
    logic [7:0]  count;
    logic [39:0] asm;
    logic [39:0] comp;
    logic [7:0]  regSel;
    logic        pendComp;
    logic        pendReg;
    logic        sending;
    logic        updTgl;
    logic        xferCompNew;
    logic        xferRegNew;
    logic [39:0] xferComp;
    logic [7:0]  xferReg;
    logic        ivcTgl;
    logic        dfTgl;
    logic [7:0]  rdData;
    logic        rdValid;
  } pic_link_state_type;

  typedef struct packed {
    logic [39:0] compLatest;
    logic [39:0] compApplied;
    logic [3:0]  regApplied;
    logic        ackTgl;
    logic        ivcFlag;
    logic        dataFlag;
    logic        cml;
    logic        alertN;
  } pic_core_state_type;

  pic_link_state_type lnk_ff;
  pic_link_state_type nxt_lnk;
  pic_core_state_type core_ff;
  pic_core_state_type nxt_core;

  logic        linkRst;
  logic        ackPulse;
  logic        updPulse;
  logic        ivcPulse;
  logic        dfPulse;
  logic [7:0]  rdLen;
  logic [47:0] rdImage;
  logic [7:0]  rdByte;
  logic [3:0]  wrCode;
  logic        wrCodeOk;

  // ----------------------------------------------------------------
  // clock domain crossings
  // ----------------------------------------------------------------
  // reset carried into the link domain
  pic_level_sync u_rst_sync (
    .clk  (linkClk),
    .din  (rst),
    .dout (linkRst)
  );

  // core acknowledges each update word
  pic_event_rx u_ack_rx (
    .clk   (linkClk),
    .rst   (linkRst),
    .tglIn (core_ff.ackTgl),
    .pulse (ackPulse)
  );

  // update word announced to the core
  pic_event_rx u_upd_rx (
    .clk   (clk),
    .rst   (rst),
    .tglIn (lnk_ff.updTgl),
    .pulse (updPulse)
  );

  // invalid-command events
  pic_event_rx u_ivc_rx (
    .clk   (clk),
    .rst   (rst),
    .tglIn (lnk_ff.ivcTgl),
    .pulse (ivcPulse)
  );

  // invalid-data events
  pic_event_rx u_df_rx (
    .clk   (clk),
    .rst   (rst),
    .tglIn (lnk_ff.dfTgl),
    .pulse (dfPulse)
  );

  // ----------------------------------------------------------------
  // read image selection
  // ----------------------------------------------------------------
  // length and byte image of the addressed command
  always_comb begin
    rdLen   = pic_pkg::LEN_NONE;
    rdImage = 48'h000000000000;
    case (lnk_ff.cmd)
      pic_pkg::CMD_CHIP_ID: begin
        rdLen   = pic_pkg::LEN_CHIP_ID;
        rdImage = CHIP_ID_VALUE;
      end
      pic_pkg::CMD_CHIP_REV: begin
        rdLen   = pic_pkg::LEN_CHIP_REV;
        rdImage = {32'h00000000, CHIP_REV_VALUE};
      end
      pic_pkg::CMD_COMP: begin
        rdLen   = pic_pkg::LEN_COMP;
        rdImage = {8'h00, lnk_ff.comp};
      end
      pic_pkg::CMD_REGV: begin
        rdLen   = pic_pkg::LEN_REGV;
        rdImage = {40'h0000000000, lnk_ff.regSel};
      end
      default: begin
        rdLen   = pic_pkg::LEN_NONE;
        rdImage = 48'h000000000000;
      end
    endcase
  end

  // count byte first, then data bytes low byte first
  always_comb begin
    rdByte = 8'h00;
    if (lnk_ff.idx == 3'h0) begin
      rdByte = rdLen;
    end else begin
      for (int i = 0; i < 6; i++) begin
        if (lnk_ff.idx == 3'(i + 1) && 8'(i) < rdLen) begin
          rdByte = rdImage[8*i +: 8];
        end
      end
    end
  end

  // regulator code check on the assembled byte
  assign wrCode   = lnk_ff.asm[pic_pkg::REGV_CODE_LSB +: 4];
  assign wrCodeOk = (wrCode >= pic_pkg::REGV_CODE_MIN) &&
                    (wrCode <= pic_pkg::REGV_CODE_MAX);

  // ----------------------------------------------------------------
  // link domain transaction logic
  // ----------------------------------------------------------------
  // byte sequencing, write commit, fault events and update handshake
  always_comb begin
    nxt_lnk         = lnk_ff;
    nxt_lnk.rdValid = 1'b0;
    if (linkCmdValid) begin
      nxt_lnk.cmd   = linkCmd;
      nxt_lnk.idx   = 3'h0;
      nxt_lnk.wrote = 1'b0;
    end else if (linkWrValid) begin
      nxt_lnk.wrote = 1'b1;
      if (lnk_ff.idx == 3'h0) begin
        nxt_lnk.count = linkWrData;
      end
      for (int i = 0; i < 5; i++) begin
        if (lnk_ff.idx == 3'(i + 1)) begin
          nxt_lnk.asm[8*i +: 8] = linkWrData;
        end
      end
      if (lnk_ff.idx != pic_pkg::IDX_SAT) begin
        nxt_lnk.idx = lnk_ff.idx + 3'h1;
      end
    end else if (linkRdReq) begin
      nxt_lnk.rdData  = rdByte;
      nxt_lnk.rdValid = 1'b1;
      if (lnk_ff.idx != pic_pkg::IDX_SAT) begin
        nxt_lnk.idx = lnk_ff.idx + 3'h1;
      end
    end else if (linkEnd && lnk_ff.wrote) begin
      nxt_lnk.wrote = 1'b0;
      case (lnk_ff.cmd)
        pic_pkg::CMD_CHIP_ID, pic_pkg::CMD_CHIP_REV: begin
          nxt_lnk.ivcTgl = ~lnk_ff.ivcTgl;
        end
        pic_pkg::CMD_COMP: begin
          if (lnk_ff.count == pic_pkg::LEN_COMP &&
              lnk_ff.idx == pic_pkg::IDX_COMP_DONE) begin
            nxt_lnk.comp     = lnk_ff.asm;
            nxt_lnk.pendComp = 1'b1;
          end else begin
            nxt_lnk.dfTgl = ~lnk_ff.dfTgl;
          end
        end
        pic_pkg::CMD_REGV: begin
          if (lnk_ff.count == pic_pkg::LEN_REGV &&
              lnk_ff.idx == pic_pkg::IDX_REGV_DONE && wrCodeOk) begin
            nxt_lnk.regSel  = {wrCode, pic_pkg::REGV_LOW_RESET};
            nxt_lnk.pendReg = 1'b1;
          end else begin
            nxt_lnk.dfTgl = ~lnk_ff.dfTgl;
          end
        end
        default: begin
          nxt_lnk.wrote = 1'b0;
        end
      endcase
    end
    // handshake: word held stable until the core acknowledges
    if (ackPulse) begin
      nxt_lnk.sending = 1'b0;
    end
    if (!nxt_lnk.sending && (nxt_lnk.pendComp || nxt_lnk.pendReg)) begin
      nxt_lnk.xferComp    = nxt_lnk.comp;
      nxt_lnk.xferReg     = nxt_lnk.regSel;
      nxt_lnk.xferCompNew = nxt_lnk.pendComp;
      nxt_lnk.xferRegNew  = nxt_lnk.pendReg;
      nxt_lnk.pendComp    = 1'b0;
      nxt_lnk.pendReg     = 1'b0;
      nxt_lnk.sending     = 1'b1;
      nxt_lnk.updTgl      = ~lnk_ff.updTgl;
    end
  end

  // link domain registers
  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      lnk_ff        <= '0;
      lnk_ff.comp   <= pic_pkg::COMP_RESET;
      lnk_ff.regSel <= {pic_pkg::REGV_CODE_RESET, pic_pkg::REGV_LOW_RESET};
    end else begin
      lnk_ff <= nxt_lnk;
    end
  end

  // ----------------------------------------------------------------
  // core domain: hardware copies and status
  // ----------------------------------------------------------------
  // apply updates, gate compensation by conversion state, track faults
  always_comb begin
    nxt_core = core_ff;
    if (updPulse) begin
      if (lnk_ff.xferCompNew) begin
        nxt_core.compLatest = lnk_ff.xferComp;
        if (!convEnable) begin
          nxt_core.compApplied = lnk_ff.xferComp;
        end
      end
      if (lnk_ff.xferRegNew) begin
        nxt_core.regApplied = lnk_ff.xferReg[pic_pkg::REGV_CODE_LSB +: 4];
      end
      nxt_core.ackTgl = ~core_ff.ackTgl;
    end
    // restore or supply cycle pushes the stored word to hardware
    if (restoreStrobe) begin
      nxt_core.compApplied = nxt_core.compLatest;
    end
    // clear first so that a coincident event wins
    if (statusClear) begin
      nxt_core.ivcFlag  = 1'b0;
      nxt_core.dataFlag = 1'b0;
    end
    if (ivcPulse) begin
      nxt_core.ivcFlag = 1'b1;
    end
    if (dfPulse) begin
      nxt_core.dataFlag = 1'b1;
    end
    nxt_core.cml    = nxt_core.ivcFlag | nxt_core.dataFlag;
    nxt_core.alertN = ~nxt_core.cml;
  end

  // core domain registers
  always_ff @(posedge clk) begin
    if (rst) begin
      core_ff             <= '0;
      core_ff.compLatest  <= pic_pkg::COMP_RESET;
      core_ff.compApplied <= pic_pkg::COMP_RESET;
      core_ff.regApplied  <= pic_pkg::REGV_CODE_RESET;
      core_ff.alertN      <= 1'b1;
    end else begin
      core_ff <= nxt_core;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from registers
  // ----------------------------------------------------------------
  // link answer
  assign linkRdData  = lnk_ff.rdData;
  assign linkRdValid = lnk_ff.rdValid;

  // current loop fields of the applied word
  assign currentIntegratorCapSelect  =
    {core_ff.compApplied[pic_pkg::CZI_HI_LSB +: 2],
     core_ff.compApplied[pic_pkg::CZI_LO_LSB +: 2]};
  assign currentFilterCapSelect      =
    core_ff.compApplied[pic_pkg::CPI_LSB +: 5];
  assign currentIntegratorMultiplier =
    core_ff.compApplied[pic_pkg::CZI_MUL_BIT];
  assign currentGainResistorSelect   =
    core_ff.compApplied[pic_pkg::RVI_LSB +: 6];

  // voltage loop fields, then the current transconductance select, of the applied word
  assign voltageIntegratorCapSelect  =
    {core_ff.compApplied[pic_pkg::CZV_HI_LSB +: 2],
     core_ff.compApplied[pic_pkg::CZV_LO_LSB +: 2]};
  assign voltageFilterCapSelect      =
    core_ff.compApplied[pic_pkg::CPV_LSB +: 5];
  assign voltageGainResistorSelect   =
    core_ff.compApplied[pic_pkg::RVV_LSB +: 6];
  assign voltageTransconductanceSelect =
    core_ff.compApplied[pic_pkg::GMV_LSB +: 2];
  assign currentTransconductanceSelect =
    core_ff.compApplied[pic_pkg::GMI_LSB +: 2];

  // regulator code and status
  assign internalRegulatorCode = core_ff.regApplied;
  assign invalidCommandFlag    = core_ff.ivcFlag;
  assign invalidDataFlag       = core_ff.dataFlag;
  assign cmlSummary            = core_ff.cml;
  assign alertN                = core_ff.alertN;
endmodule : pic_pmbus_regs
`default_nettype wire

//--- tb/pic_host_model.sv
// link-side host model issuing block reads and writes
`default_nettype none
module pic_host_model (
  input  wire logic       linkClk,
  output logic            linkCmdValid,
  output logic      [7:0] linkCmd,
  output logic            linkWrValid,
  output logic      [7:0] linkWrData,
  output logic            linkRdReq,
  output logic            linkEnd,
  input  wire logic [7:0] linkRdData,
  input  wire logic       linkRdValid
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle at time zero
  initial begin
    linkCmdValid = 1'b0;
    linkWrValid  = 1'b0;
    linkRdReq    = 1'b0;
    linkEnd      = 1'b0;
    linkCmd      = 8'h5a;
    linkWrData   = 8'ha5;
  end

  // one strobe for one cycle; payload turns over once released
  task automatic send(input logic [1:0] k, input logic [7:0] v);
    @(negedge linkClk);
    linkCmdValid = (k == 2'h0);
    linkWrValid  = (k == 2'h1);
    linkEnd      = (k == 2'h2);
    linkRdReq    = (k == 2'h3);
    linkCmd      = v;
    linkWrData   = v;
    @(negedge linkClk);
    linkCmdValid = 1'b0;
    linkWrValid  = 1'b0;
    linkEnd      = 1'b0;
    linkRdReq    = 1'b0;
    linkCmd      = ~v;
    linkWrData   = ~v;
  endtask : send

  // one read byte, taken when the answer pulse shows
  task automatic rd(output logic [7:0] b);
    int n;
    send(2'h3, 8'h00);
    n = 0;
    while (!linkRdValid && n < 3) begin
      @(negedge linkClk);
      n++;
    end
    b = linkRdValid ? linkRdData : 8'hxx;
  endtask : rd

  // command, count byte, data bytes low first, stop
  task automatic wr_block(input logic [7:0] c, input logic [7:0] cnt,
                          input int n, input logic [47:0] d);
    if (c == pic_pkg::CMD_COMP) d = d & 48'hfffffeff33;
    if (c == pic_pkg::CMD_REGV) d[3:0] = 4'h0;
    send(2'h0, c);
    send(2'h1, cnt);
    for (int i = 0; i < n; i++) begin
      send(2'h1, d[8*i +: 8]);
    end
    send(2'h2, 8'h00);
  endtask : wr_block

  // command, count byte, then six bytes whatever the length
  task automatic rd_block(input logic [7:0] c, output logic [7:0] cnt,
                          output logic [47:0] d);
    logic [7:0] b;
    send(2'h0, c);
    rd(cnt);
    for (int i = 0; i < 6; i++) begin
      rd(b);
      d[8*i +: 8] = b;
    end
  endtask : rd_block
endmodule : pic_host_model
`default_nettype wire

//--- tb/pic_pmbus_regs_props.sv
// port-level checks for the identity, compensation and regulator registers
`default_nettype none
module pic_pmbus_regs_props (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       linkClk,
  input wire logic       linkCmdValid,
  input wire logic       linkWrValid,
  input wire logic       linkRdReq,
  input wire logic       linkRdValid,
  input wire logic       convEnable,
  input wire logic       restoreStrobe,
  input wire logic       statusClear,
  input wire logic [3:0] currentIntegratorCapSelect,
  input wire logic [4:0] currentFilterCapSelect,
  input wire logic       currentIntegratorMultiplier,
  input wire logic [5:0] currentGainResistorSelect,
  input wire logic [3:0] voltageIntegratorCapSelect,
  input wire logic [4:0] voltageFilterCapSelect,
  input wire logic [5:0] voltageGainResistorSelect,
  input wire logic [1:0] voltageTransconductanceSelect,
  input wire logic [1:0] currentTransconductanceSelect,
  input wire logic [3:0] internalRegulatorCode,
  input wire logic       invalidCommandFlag,
  input wire logic       invalidDataFlag,
  input wire logic       cmlSummary,
  input wire logic       alertN
);
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------
  // helper history and checks
  // ------------------------------------------
  logic [34:0] applied;
  logic [2:0]  convHist;
  logic [2:0]  restHist;

  // all applied fields side by side
  assign applied = {currentIntegratorCapSelect, currentFilterCapSelect,
    currentIntegratorMultiplier, currentGainResistorSelect,
    voltageIntegratorCapSelect, voltageFilterCapSelect,
    voltageGainResistorSelect, voltageTransconductanceSelect,
    currentTransconductanceSelect};

  // last three samples of enable and restore
  always_ff @(posedge clk) begin
    convHist <= {convHist[1:0], convEnable};
    restHist <= {restHist[1:0], restoreStrobe};
  end

  a_alert_level: assert property (@(posedge clk) disable iff (rst)
    alertN == !cmlSummary)
    else $error("alert line disagrees with summary");
  a_summary_set: assert property (@(posedge clk) disable iff (rst)
    $rose(invalidCommandFlag) || $rose(invalidDataFlag) |-> ##[0:1] cmlSummary)
    else $error("summary not set by a fault");
  a_cmd_sticky: assert property (@(posedge clk) disable iff (rst)
    invalidCommandFlag && !statusClear |=> invalidCommandFlag)
    else $error("command fault dropped without clear");
  a_data_sticky: assert property (@(posedge clk) disable iff (rst)
    invalidDataFlag && !statusClear |=> invalidDataFlag)
    else $error("data fault dropped without clear");
  a_clear_only: assert property (@(posedge clk) disable iff (rst)
    $fell(invalidCommandFlag) || $fell(invalidDataFlag)
    |-> $past(statusClear) || $past(statusClear, 2))
    else $error("fault fell with no clear");
  a_comp_frozen: assert property (@(posedge clk) disable iff (rst)
    convEnable && (&convHist) && !(|restHist) |-> $stable(applied))
    else $error("compensation moved while converting");
  a_regv_range: assert property (@(posedge clk) disable iff (rst)
    internalRegulatorCode inside
      {[pic_pkg::REGV_CODE_MIN:pic_pkg::REGV_CODE_MAX]})
    else $error("regulator code out of range");
  a_rd_answer: assert property (@(posedge linkClk) disable iff (rst)
    linkRdReq && !linkCmdValid && !linkWrValid |=> linkRdValid)
    else $error("read byte not answered");
  a_rd_quiet: assert property (@(posedge linkClk) disable iff (rst)
    !linkRdReq |=> !linkRdValid)
    else $error("read answer without request");

  // main scenarios reached
  c_cmd_fault: cover property (@(posedge clk) $rose(invalidCommandFlag));
  c_data_fault: cover property (@(posedge clk) $rose(invalidDataFlag));
  c_regv_move: cover property (@(posedge clk) $changed(internalRegulatorCode));
  c_read_back: cover property (@(posedge linkClk) linkRdValid);
endmodule : pic_pmbus_regs_props

bind pic_pmbus_regs pic_pmbus_regs_props u_props (
  .clk, .rst, .linkClk, .linkCmdValid, .linkWrValid, .linkRdReq,
  .linkRdValid, .convEnable, .restoreStrobe, .statusClear,
  .currentIntegratorCapSelect, .currentFilterCapSelect,
  .currentIntegratorMultiplier, .currentGainResistorSelect,
  .voltageIntegratorCapSelect, .voltageFilterCapSelect,
  .voltageGainResistorSelect, .voltageTransconductanceSelect,
  .currentTransconductanceSelect, .internalRegulatorCode,
  .invalidCommandFlag, .invalidDataFlag, .cmlSummary, .alertN
);
`default_nettype wire

//--- tb/tb.sv
// self-checking bench for the identity, compensation and regulator registers
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [7:0]  cmd;
    logic [7:0]  cnt;
    logic [47:0] dat;
  } pic_row_type;

  localparam logic [47:0] ID  = 48'ha1b2c3d4e5f6; // arbitrary
  localparam logic [15:0] REV = 16'h2301;         // arbitrary

  logic        clk = 1'b0;
  logic        linkClk = 1'b0;
  logic        rst, convEnable, restoreStrobe, statusClear;
  logic        linkCmdValid, linkWrValid, linkRdReq, linkEnd, linkRdValid;
  logic [7:0]  linkCmd, linkWrData, linkRdData, cnt;
  logic [3:0]  internalRegulatorCode, last;
  logic        invalidCommandFlag, invalidDataFlag, cmlSummary, alertN;
  wire  [34:0] applied;
  logic [47:0] dat;
  logic [39:0] w1, w2;
  int          miscompares, cmpCount, cycles;
  bit          ok;
  pic_row_type rows [5] = '{
    '{pic_pkg::CMD_CHIP_ID, pic_pkg::LEN_CHIP_ID, ID},
    '{pic_pkg::CMD_CHIP_REV, pic_pkg::LEN_CHIP_REV, {32'h0, REV}},
    '{pic_pkg::CMD_COMP, pic_pkg::LEN_COMP, 48'h0},
    '{pic_pkg::CMD_REGV, pic_pkg::LEN_REGV, 48'h90},
    '{8'h00, pic_pkg::LEN_NONE, 48'h0}};

  // core clock and an unrelated link clock
  always #10 clk = ~clk;
  initial begin
    #37;
    forever #80 linkClk = ~linkClk;
  end

  pic_pmbus_regs #(.CHIP_ID_VALUE(ID), .CHIP_REV_VALUE(REV)) dut (
    .clk, .rst, .linkClk, .linkCmdValid, .linkCmd, .linkWrValid,
    .linkWrData, .linkRdReq, .linkEnd, .linkRdData, .linkRdValid,
    .convEnable, .restoreStrobe, .statusClear,
    .currentIntegratorCapSelect(applied[34:31]),
    .currentFilterCapSelect(applied[30:26]),
    .currentIntegratorMultiplier(applied[25]),
    .currentGainResistorSelect(applied[24:19]),
    .voltageIntegratorCapSelect(applied[18:15]),
    .voltageFilterCapSelect(applied[14:10]),
    .voltageGainResistorSelect(applied[9:4]),
    .voltageTransconductanceSelect(applied[3:2]),
    .currentTransconductanceSelect(applied[1:0]),
    .internalRegulatorCode, .invalidCommandFlag, .invalidDataFlag,
    .cmlSummary, .alertN);

  pic_host_model host (.linkClk, .linkCmdValid, .linkCmd, .linkWrValid,
    .linkWrData, .linkRdReq, .linkEnd, .linkRdData, .linkRdValid);

  // expected applied fields of a compensation word
  function automatic logic [34:0] exp_of(input logic [39:0] w);
    return {w[25:24], w[39:38], w[37:33], w[32],
      w[31:26], w[9:8], w[23:22], w[21:17],
      w[15:10], w[5:4], w[1:0]};
  endfunction : exp_of

  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    cmpCount++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmpCount, miscompares);
    if (miscompares == 0 && cmpCount > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  // core strobe pulse, then time for the outputs to follow
  task automatic strobe(input bit clr);
    @(negedge clk);
    statusClear = clr;
    restoreStrobe = !clr;
    @(negedge clk);
    statusClear = 1'b0;
    restoreStrobe = 1'b0;
    repeat (2) @(negedge clk);
  endtask : strobe

  // room for the link edge, the crossing and the applied register
  task automatic settle;
    repeat (40) @(negedge clk);
  endtask : settle

  task automatic do_reset;
    @(negedge clk);
    rst = 1'b1;
    repeat (8) @(posedge linkClk);
    @(negedge clk);
    rst = 1'b0;
    repeat (4) @(posedge linkClk);
    @(negedge clk);
    check({applied, internalRegulatorCode}, {35'h0, 4'h9});
    check({invalidCommandFlag, invalidDataFlag, cmlSummary, alertN},
          4'h1);
  endtask : do_reset

  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares++;
      print_verdict();
    end
  end

  initial begin
    rst = 1'b1;
    convEnable = 1'b0;
    restoreStrobe = 1'b0;
    statusClear = 1'b0;
    do_reset();
    foreach (rows[i]) begin
      host.rd_block(rows[i].cmd, cnt, dat);
      check(cnt, rows[i].cnt);
      check(dat, rows[i].dat);
    end
    $display("read table done");
    for (int i = 0; i < 2; i++) begin
      host.wr_block(i ? pic_pkg::CMD_CHIP_REV : pic_pkg::CMD_CHIP_ID,
                    8'h01, 1, 48'h0);
      settle();
      check({invalidCommandFlag, invalidDataFlag, cmlSummary, alertN},
            4'ha);
      strobe(1'b1);
      check({invalidCommandFlag, cmlSummary, alertN}, 3'h1);
    end
    $display("read-only write done");
    w1 = {2'h2, 5'h15, 1'h1, 6'h2d, 2'h1, 2'h3, 5'h0b, 1'h0, 6'h36,
          2'h2, 2'h0, 2'h1, 2'h0, 2'h2};
    host.wr_block(pic_pkg::CMD_COMP, 8'h05, 5, {8'h0, w1});
    settle();
    check(applied, exp_of(w1));
    convEnable = 1'b1;
    w2 = w1 ^ 40'hfffffeff33;
    host.wr_block(pic_pkg::CMD_COMP, 8'h05, 5, {8'h0, w2});
    settle();
    check(applied, exp_of(w1));
    host.rd_block(pic_pkg::CMD_COMP, cnt, dat);
    check(dat, {8'h0, w2});
    strobe(1'b0);
    check(applied, exp_of(w2));
    convEnable = 1'b0;
    host.wr_block(pic_pkg::CMD_COMP, 8'h04, 4, 48'h0);
    settle();
    check({invalidDataFlag, cmlSummary, alertN, applied},
          {3'h6, exp_of(w2)});
    host.rd_block(pic_pkg::CMD_COMP, cnt, dat);
    check(dat, {8'h0, w2});
    strobe(1'b1);
    $display("compensation done");
    // every code; codes below 3 and above 10 are expected to raise the data fault
    last = 4'h9;
    for (int c = 0; c < 16; c++) begin
      host.wr_block(pic_pkg::CMD_REGV, 8'h01, 1, 48'(c) << 4);
      settle();
      ok = c >= 3 && c <= 10;
      if (ok) last = c[3:0];
      check({invalidDataFlag, internalRegulatorCode},
            {!ok, last});
      host.rd_block(pic_pkg::CMD_REGV, cnt, dat);
      check(dat, {40'h0, last, 4'h0});
      strobe(1'b1);
    end
    $display("regulator codes done");
    do_reset();
    host.rd_block(pic_pkg::CMD_REGV, cnt, dat);
    check(dat, 48'h90);
    $display("second reset done");
    print_verdict();
  end
endmodule : tb
`default_nettype wire
